// >>> sac_top.sv
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
module sac_top
    import sac_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clk, // system clock, 50 MHz
    input wire logic rst_b, // synchronous reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr // apb error, unmapped address
);

    // ========================================
    // state
    logic [31:0] opa_reg;
    logic [31:0] opb_reg;
    logic [31:0] instr_reg;
    logic [31:0] result_reg;
    logic [31:0] ctl_reg;
    logic enable_reg;
    sac_status_type status_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;

    logic setup;
    logic wr_go;
    logic exec_go;
    logic [31:0] rd_data;
    logic mapped;
    sac_op_type op;
    sac_exec_type ex;
    logic [31:0] ph_wrap;
    logic [31:0] ph_sat;
    logic ph_carry;
    logic [31:0] qb_wrap;
    logic [31:0] qb_sat;
    logic qb_carry;
    logic [32:0] wc_sum;
    logic [32:0] sc_sum;
    logic carry_bit;
    logic ovf_bit;

    // ========================================
    // helpers
    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] off);
        hit = (addr == ADDR_W'(off));
    endfunction

    function automatic sac_op_type sac_decode(input logic [31:0] ins);
        logic [10:0] minor;
        minor = ins[SAC_MIN_W-1:0];
        sac_decode = OP_RSVD;
        if (ins[SAC_MAJ_LSB +: 6] == SAC_MAJOR_A) begin
            if (minor == SAC_MIN_PH) begin
                sac_decode = OP_PH;
            end else if (minor == SAC_MIN_PH_S) begin
                sac_decode = OP_PH_S;
            end else if (minor == SAC_MIN_QB) begin
                sac_decode = OP_QB;
            end else if (minor == SAC_MIN_QB_S) begin
                sac_decode = OP_QB_S;
            end else if (!ins[SAC_WC_ZERO_BIT] && minor[SAC_MIN10_W-1:0] == SAC_MIN10_WC) begin
                sac_decode = OP_WC;
            end else if (!ins[SAC_WC_ZERO_BIT] && minor[SAC_MIN10_W-1:0] == SAC_MIN10_SC) begin
                sac_decode = OP_SC;
            end
        end
    endfunction

    // ========================================
    // apb slave, zero wait states
    assign setup = psel && !penable;
    assign wr_go = psel && penable && pready_reg && pwrite && !pslverr_reg;
    assign exec_go = wr_go && hit(paddr, SAC_OFF_INSTR);
    assign carry_bit = ctl_reg[SAC_CARRY_BIT];
    assign ovf_bit = ctl_reg[SAC_OUFLAG_BIT];

    always_comb begin
        mapped = 1'b1;
        rd_data = 32'h0000_0000;
        if (hit(paddr, SAC_OFF_OPA)) begin
            rd_data = opa_reg;
        end else if (hit(paddr, SAC_OFF_OPB)) begin
            rd_data = opb_reg;
        end else if (hit(paddr, SAC_OFF_INSTR)) begin
            rd_data = instr_reg;
        end else if (hit(paddr, SAC_OFF_RESULT)) begin
            rd_data = result_reg;
        end else if (hit(paddr, SAC_OFF_CTL)) begin
            rd_data = ctl_reg;
        end else if (hit(paddr, SAC_OFF_STATUS)) begin
            rd_data = {29'h0, status_reg};
        end else if (hit(paddr, SAC_OFF_ENABLE)) begin
            rd_data = {31'h0, enable_reg};
        end else begin
            mapped = 1'b0;
        end
    end

    // answer is prepared in setup so every output leaves a flip-flop
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= setup;
            pslverr_reg <= setup && !mapped;
            if (setup && !pwrite) begin
                prdata_reg <= rd_data;
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    // ========================================
    // operand and enable registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            opa_reg <= 32'h0000_0000;
            opb_reg <= 32'h0000_0000;
            instr_reg <= 32'h0000_0000;
            enable_reg <= SAC_ENABLE_RESET;
        end else if (wr_go) begin
            if (hit(paddr, SAC_OFF_OPA)) begin
                opa_reg <= pwdata;
            end
            if (hit(paddr, SAC_OFF_OPB)) begin
                opb_reg <= pwdata;
            end
            if (hit(paddr, SAC_OFF_INSTR)) begin
                instr_reg <= pwdata;
            end
            if (hit(paddr, SAC_OFF_ENABLE)) begin
                enable_reg <= pwdata[0];
            end
        end
    end

    // ========================================
    // datapath
    sac_packed_adder #(
        .LANE_W(16)
    ) u_half (
        .a(opa_reg),
        .b(opb_reg),
        .sum_wrap(ph_wrap),
        .sum_sat(ph_sat),
        .carry_any(ph_carry)
    );

    sac_packed_adder #(
        .LANE_W(8)
    ) u_byte (
        .a(opa_reg),
        .b(opb_reg),
        .sum_wrap(qb_wrap),
        .sum_sat(qb_sat),
        .carry_any(qb_carry)
    );

    assign wc_sum = {opa_reg[31], opa_reg} + {opb_reg[31], opb_reg} + {32'h0, carry_bit};
    assign sc_sum = {1'b0, opa_reg} + {1'b0, opb_reg};

    // unknown codes trap before the enable is looked at; neither trap depends on operand values
    always_comb begin
        ex = '0;
        op = sac_decode(pwdata);
        if (op == OP_RSVD) begin
            ex.rsvd_exc = 1'b1;
        end else if (!enable_reg) begin
            ex.dis_exc = 1'b1;
        end else begin
            ex.write_rd = 1'b1;
            unique case (op)
                OP_RSVD: begin
                    ex.write_rd = 1'b0;
                end
                OP_PH: begin
                    ex.result = ph_wrap;
                    ex.set_ovf = ph_carry;
                end
                OP_PH_S: begin
                    ex.result = ph_sat;
                    ex.set_ovf = ph_carry;
                end
                OP_QB: begin
                    ex.result = qb_wrap;
                    ex.set_ovf = qb_carry;
                end
                OP_QB_S: begin
                    ex.result = qb_sat;
                    ex.set_ovf = qb_carry;
                end
                OP_WC: begin
                    ex.result = wc_sum[31:0];
                    ex.set_ovf = wc_sum[32] != wc_sum[31];
                end
                OP_SC: begin
                    ex.result = sc_sum[31:0];
                    ex.write_carry = 1'b1;
                    ex.carry = sc_sum[32];
                end
            endcase
        end
    end

    // ========================================
    // result and status
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            result_reg <= 32'h0000_0000;
        end else if (exec_go && ex.write_rd) begin
            result_reg <= ex.result;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            status_reg <= '0;
        end else if (exec_go) begin
            status_reg <= '{dis_exc: ex.dis_exc, rsvd_exc: ex.rsvd_exc, done: ex.write_rd};
        end
    end

    // ========================================
    // control register: software owns it, the adds only set the flag and load the carry
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctl_reg <= SAC_CTL_RESET;
        end else if (wr_go && hit(paddr, SAC_OFF_CTL)) begin
            ctl_reg <= pwdata;
        end else if (exec_go) begin
            if (ex.set_ovf) begin
                ctl_reg[SAC_OUFLAG_BIT] <= 1'b1;
            end
            if (ex.write_carry) begin
                ctl_reg[SAC_CARRY_BIT] <= ex.carry;
            end
        end
    end

    // ========================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic go_on;
    logic [32:0] chk_wc;
    logic [32:0] chk_sc;
    sac_op_type chk_op;
    assign chk_op = sac_decode(pwdata);
    assign go_on = exec_go && enable_reg;
    assign chk_wc = {opa_reg[31], opa_reg} + {opb_reg[31], opb_reg} + 33'(carry_bit);
    assign chk_sc = 33'(opa_reg) + 33'(opb_reg);

    property p_ph_wrap;
        go_on && chk_op == OP_PH |=> result_reg ==
            {16'(opa_reg[31:16] + opb_reg[31:16]), 16'(opa_reg[15:0] + opb_reg[15:0])};
    endproperty
    a_ph_wrap: assert property (p_ph_wrap) else $error("halfword wrap sum wrong");

    property p_ph_sat;
        go_on && chk_op == OP_PH_S |=>
            result_reg[15:0] == ((17'(opa_reg[15:0]) + 17'(opb_reg[15:0]) > 17'h0ffff) ?
            16'hffff : 16'(opa_reg[15:0] + opb_reg[15:0]));
    endproperty
    a_ph_sat: assert property (p_ph_sat) else $error("halfword saturation wrong");

    property p_qb_wrap;
        go_on && chk_op == OP_QB |=> result_reg ==
            {8'(opa_reg[31:24] + opb_reg[31:24]), 8'(opa_reg[23:16] + opb_reg[23:16]),
            8'(opa_reg[15:8] + opb_reg[15:8]), 8'(opa_reg[7:0] + opb_reg[7:0])};
    endproperty
    a_qb_wrap: assert property (p_qb_wrap) else $error("byte wrap sum wrong");

    property p_qb_sat;
        go_on && chk_op == OP_QB_S |=>
            result_reg[31:24] == ((9'(opa_reg[31:24]) + 9'(opb_reg[31:24]) > 9'h0ff) ?
            8'hff : 8'(opa_reg[31:24] + opb_reg[31:24]));
    endproperty
    a_qb_sat: assert property (p_qb_sat) else $error("byte saturation wrong");

    property p_ph_ovf;
        go_on && (chk_op == OP_PH || chk_op == OP_PH_S) &&
            (17'(opa_reg[31:16]) + 17'(opb_reg[31:16]) > 17'h0ffff) |=> ovf_bit;
    endproperty
    a_ph_ovf: assert property (p_ph_ovf) else $error("halfword overflow flag not set");

    property p_qb_ovf;
        go_on && (chk_op == OP_QB || chk_op == OP_QB_S) &&
            (9'(opa_reg[23:16]) + 9'(opb_reg[23:16]) > 9'h0ff) |=> ovf_bit;
    endproperty
    a_qb_ovf: assert property (p_qb_ovf) else $error("byte overflow flag not set");

    property p_wc_sum;
        go_on && chk_op == OP_WC |=> result_reg == 32'(opa_reg + opb_reg + 32'($past(carry_bit)));
    endproperty
    a_wc_sum: assert property (p_wc_sum) else $error("carry add sum wrong");

    property p_wc_ovf;
        go_on && chk_op == OP_WC && (chk_wc[32] != chk_wc[31]) |=> ovf_bit;
    endproperty
    a_wc_ovf: assert property (p_wc_ovf) else $error("carry add overflow flag not set");

    property p_sc_carry;
        go_on && chk_op == OP_SC |=> carry_bit == chk_sc[32] && ovf_bit == $past(ovf_bit);
    endproperty
    a_sc_carry: assert property (p_sc_carry) else $error("carry bit not stored");

    property p_ovf_sticky;
        ovf_bit && !(wr_go && hit(paddr, SAC_OFF_CTL)) |=> ovf_bit;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag cleared by hardware");

    property p_no_ovf;
        exec_go && !ex.set_ovf && chk_op != OP_SC |=> $stable(ctl_reg) [*2];
    endproperty
    a_no_ovf: assert property (p_no_ovf) else $error("control changed without overflow");

    property p_exc;
        exec_go && (chk_op == OP_RSVD || !enable_reg) |=>
            $stable(result_reg) && $stable(ctl_reg) && !status_reg.done;
    endproperty
    a_exc: assert property (p_exc) else $error("trapped instruction changed state");

    property p_apb_ready;
        setup |=> pready ##1 !pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("ready not a single access cycle");

    c_ph_clamp: cover property (go_on && chk_op == OP_PH_S && ph_carry);
    c_wc_ovf: cover property (go_on && chk_op == OP_WC ##1 ovf_bit);
    c_sc_then_wc: cover property (go_on && chk_op == OP_SC ##[1:20] go_on && chk_op == OP_WC);
    c_rsvd: cover property (exec_go && chk_op == OP_RSVD);

endmodule

// >>> sac_pkg.sv
// Functional notes
// - decode halfword-pair add, group 000000, minor 00100001101 wrap, 10100001101 saturating.
// - split operands into halfword lanes 31..16 and 15..0, results packed in place.
// - wrapping halfword add writes each lane sum modulo 65,536.
// - saturating halfword add clamps an overflowing lane to 0xFFFF.
// - decode byte-quad add, group 000000, minor 00011001101 wrap, 10011001101 saturating.
// - treat operands as four byte lanes 31..24 down to 7..0, packed in place.
// - wrapping byte add writes each lane sum modulo 256.
// - saturating byte add clamps an overflowing lane to 0xFF.
// - any lane carry-out in a packed add sets overflow flag bit 20.
// - decode add-with-carry, group 000000, bit 10 zero, minor 1111000101.
// - add-with-carry writes low 32 bits of a plus b plus carry bit 13.
// - add-with-carry sets bit 20 when top two bits of signed sum differ.
// - only reserved-instruction or disabled exceptions; never operand-dependent ones.
// - carry-setting add stores its unsigned 32-bit carry-out into bit 13.
package sac_pkg;

    // ========================================
    // register map, byte addresses
    localparam logic [7:0] SAC_OFF_OPA = 8'h00;
    localparam logic [7:0] SAC_OFF_OPB = 8'h04;
    localparam logic [7:0] SAC_OFF_INSTR = 8'h08;
    localparam logic [7:0] SAC_OFF_RESULT = 8'h0c;
    localparam logic [7:0] SAC_OFF_CTL = 8'h10;
    localparam logic [7:0] SAC_OFF_STATUS = 8'h14;
    localparam logic [7:0] SAC_OFF_ENABLE = 8'h18;

    // ========================================
    // reset values and control fields
    localparam logic [31:0] SAC_CTL_RESET = 32'h0000_0000;
    localparam logic SAC_ENABLE_RESET = 1'b1;
    localparam int SAC_CARRY_BIT = 13;
    localparam int SAC_OUFLAG_BIT = 20;

    // ========================================
    // instruction fields and codes
    localparam int SAC_MAJ_LSB = 26;
    localparam int SAC_MIN_W = 11;
    localparam int SAC_MIN10_W = 10;
    localparam int SAC_WC_ZERO_BIT = 10;
    localparam logic [5:0] SAC_MAJOR_A = 6'h00;
    localparam logic [10:0] SAC_MIN_PH = 11'h10d;
    localparam logic [10:0] SAC_MIN_PH_S = 11'h50d;
    localparam logic [10:0] SAC_MIN_QB = 11'h0cd;
    localparam logic [10:0] SAC_MIN_QB_S = 11'h4cd;
    localparam logic [9:0] SAC_MIN10_WC = 10'h3c5;
    localparam logic [9:0] SAC_MIN10_SC = 10'h385;

    // ========================================
    // types
    typedef enum logic [6:0] {
        OP_RSVD = 7'h01,
        OP_PH = 7'h02,
        OP_PH_S = 7'h04,
        OP_QB = 7'h08,
        OP_QB_S = 7'h10,
        OP_WC = 7'h20,
        OP_SC = 7'h40
    } sac_op_type;

    typedef struct packed {
        logic [31:0] result;
        logic write_rd;
        logic set_ovf;
        logic write_carry;
        logic carry;
        logic rsvd_exc;
        logic dis_exc;
    } sac_exec_type;

    typedef struct packed {
        logic dis_exc;
        logic rsvd_exc;
        logic done;
    } sac_status_type;

endpackage

// >>> sac_packed_adder.sv
`timescale 1ns/100ps
module sac_packed_adder
    import sac_pkg::*;
#(
    parameter int LANE_W = 16
) (
    input wire logic [31:0] a, // first packed operand
    input wire logic [31:0] b, // second packed operand
    output logic [31:0] sum_wrap, // lane sums, carries dropped
    output logic [31:0] sum_sat, // lane sums clamped to all ones
    output logic carry_any // some lane carried out
);
    localparam int LANES = 32 / LANE_W;

    logic [LANES-1:0] carry;

    // ========================================
    // lane adders, lane i holds bits i*LANE_W upward
    genvar i;
    generate
        for (i = 0; i < LANES; i++) begin : g_lane
            logic [LANE_W:0] s;
            assign s = {1'b0, a[i*LANE_W +: LANE_W]} + {1'b0, b[i*LANE_W +: LANE_W]};
            assign carry[i] = s[LANE_W];
            assign sum_wrap[i*LANE_W +: LANE_W] = s[LANE_W-1:0];
            assign sum_sat[i*LANE_W +: LANE_W] = s[LANE_W] ? {LANE_W{1'b1}} : s[LANE_W-1:0];
        end
    endgenerate

    assign carry_any = |carry;
endmodule

// >>> sac_pipe_model.sv
`timescale 1ns/100ps
// =====================================
// pipeline-side view: what one issued word must leave in the destination and control
module sac_pipe_model
    import sac_pkg::*;
(
    input wire logic [31:0] instr, // issued instruction word
    input wire logic [31:0] a, // source_reg_a value
    input wire logic [31:0] b, // source_reg_b value
    input wire logic [31:0] ctl, // signal_proc_ctl_reg before issue
    input wire logic en, // extension enabled
    input wire logic [31:0] prev, // destination before issue
    output logic [31:0] res, // destination after issue
    output logic [31:0] ctl_out, // control after issue
    output logic [31:0] status // done, reserved, disabled
);
    logic [16:0] s17;
    logic [8:0] s9;
    logic [32:0] s33;
    logic [31:0] wr16, sat16, wr8, sat8;
    logic ov16, ov8, known;
    logic [10:0] mn;

    always_comb begin
        mn = instr[10:0];
        ov16 = 1'b0;
        ov8 = 1'b0;
        for (int i = 0; i < 2; i++) begin
            s17 = {1'b0, a[16*i+:16]} + {1'b0, b[16*i+:16]};
            ov16 = ov16 | s17[16];
            wr16[16*i+:16] = s17[15:0];
            sat16[16*i+:16] = s17[16] ? 16'hffff : s17[15:0];
        end
        for (int i = 0; i < 4; i++) begin
            s9 = {1'b0, a[8*i+:8]} + {1'b0, b[8*i+:8]};
            ov8 = ov8 | s9[8];
            wr8[8*i+:8] = s9[7:0];
            sat8[8*i+:8] = s9[8] ? 8'hff : s9[7:0];
        end
        known = 1'b1;
        res = prev;
        ctl_out = ctl;
        s33 = 33'h0;
        // major group first, then minor code or 10-bit code with bit 10 clear
        if (instr[31:26] !== SAC_MAJOR_A) begin
            known = 1'b0;
        end else if (mn == SAC_MIN_PH || mn == SAC_MIN_PH_S) begin
            res = (mn == SAC_MIN_PH) ? wr16 : sat16;
            ctl_out[SAC_OUFLAG_BIT] = ctl[SAC_OUFLAG_BIT] | ov16;
        end else if (mn == SAC_MIN_QB || mn == SAC_MIN_QB_S) begin
            res = (mn == SAC_MIN_QB) ? wr8 : sat8;
            ctl_out[SAC_OUFLAG_BIT] = ctl[SAC_OUFLAG_BIT] | ov8;
        end else if (!instr[10] && instr[9:0] == SAC_MIN10_WC) begin
            s33 = {a[31], a} + {b[31], b} + {32'h0, ctl[SAC_CARRY_BIT]};
            res = s33[31:0];
            ctl_out[SAC_OUFLAG_BIT] = ctl[SAC_OUFLAG_BIT] | (s33[32] ^ s33[31]);
        end else if (!instr[10] && instr[9:0] == SAC_MIN10_SC) begin
            s33 = {1'b0, a} + {1'b0, b};
            res = s33[31:0];
            ctl_out[SAC_CARRY_BIT] = s33[32];
        end else begin
            known = 1'b0;
        end
        // an excepted word leaves destination and control alone
        if (!known || !en) begin
            res = prev;
            ctl_out = ctl;
        end
        status = {29'h0, known & ~en, ~known, known & en};
    end
endmodule

// >>> tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import sac_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] m_instr = 32'h0;
    logic [31:0] m_a = 32'h0;
    logic [31:0] m_b = 32'h0;
    logic [31:0] m_ctl = 32'h0;
    logic [31:0] m_prev = 32'h0;
    logic m_en = 1'b1;
    logic [31:0] e_res, e_ctl, e_stat;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;

    sac_top #(.ADDR_W(8)) dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    sac_pipe_model model (.instr(m_instr), .a(m_a), .b(m_b), .ctl(m_ctl), .en(m_en), .prev(m_prev),
        .res(e_res), .ctl_out(e_ctl), .status(e_stat));

    initial begin
        forever #10 clk = ~clk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // a hung bus would otherwise stall the run forever
    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            n_fail++;
            complete_run();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // =====================================
    // apb master: setup, access until pready, then release
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
        output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // only the run's cycle ceiling ends a wait that never sees pready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
        check("write error", {31'h0, e}, 32'h0);
    endtask

    task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        check(name, q, exp);
    endtask

    function automatic logic [31:0] mk(input logic [10:0] mn);
        return {SAC_MAJOR_A, 5'd2, 5'd1, 5'd3, mn};
    endfunction

    // operands are plain unsigned packed words, as software must give them
    task automatic exec(input logic [31:0] instr, input logic [31:0] a, input logic [31:0] b,
        input logic [31:0] ctl);
        wr(SAC_OFF_OPA, a);
        wr(SAC_OFF_OPB, b);
        wr(SAC_OFF_CTL, ctl);
        m_instr = instr;
        m_a = a;
        m_b = b;
        m_ctl = ctl;
        #1;
        wr(SAC_OFF_INSTR, instr);
        rd("result", SAC_OFF_RESULT, e_res);
        rd("control", SAC_OFF_CTL, e_ctl);
        rd("status", SAC_OFF_STATUS, e_stat);
        m_prev = e_res;
    endtask

    // =====================================
    // main sequence
    initial begin
        logic [31:0] q;
        logic e;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        rd("ctl reset", SAC_OFF_CTL, SAC_CTL_RESET);
        rd("enable reset", SAC_OFF_ENABLE, {31'h0, SAC_ENABLE_RESET});
        rd("result reset", SAC_OFF_RESULT, 32'h0);
        rd("status reset", SAC_OFF_STATUS, 32'h0);
        apb(1'b0, 8'h1c, 32'h0, q, e);
        check("unmapped read error", {31'h0, e}, 32'h1);
        apb(1'b1, 8'h1c, 32'h5a5a_5a5a, q, e);
        check("unmapped write error", {31'h0, e}, 32'h1);
        exec(mk(SAC_MIN_PH), 32'hffff_0001, 32'h0001_0002, 32'h0);
        exec(mk(SAC_MIN_PH_S), 32'hffff_0001, 32'h0001_0002, 32'h0);
        exec(mk(SAC_MIN_PH), 32'h1234_0fff, 32'h0001_f000, 32'h0010_2005);
        exec(mk(SAC_MIN_PH_S), 32'h0001_8000, 32'h0001_8000, 32'h0);
        exec(mk(SAC_MIN_QB), 32'h80ff_017f, 32'h8001_0101, 32'h0);
        exec(mk(SAC_MIN_QB_S), 32'h80ff_017f, 32'h8001_0101, 32'h0);
        exec(mk(SAC_MIN_QB_S), 32'h0102_7f10, 32'h0304_8020, 32'h0000_2000);
        exec(mk({1'b0, SAC_MIN10_WC}), 32'h7fff_ffff, 32'h0, 32'h0000_2000);
        exec(mk({1'b0, SAC_MIN10_WC}), 32'hffff_ffff, 32'h1, 32'h0);
        exec(mk({1'b0, SAC_MIN10_WC}), 32'h8000_0000, 32'h8000_0000, 32'h0000_2000);
        exec(mk({1'b0, SAC_MIN10_SC}), 32'hffff_ffff, 32'h1, 32'h0);
        exec(mk({1'b0, SAC_MIN10_SC}), 32'h1, 32'h1, 32'h0010_2000);
        exec(mk({1'b0, SAC_MIN10_WC}), 32'h1, 32'h2, 32'h0000_2000);
        exec(mk(11'h7ff), 32'hffff_ffff, 32'hffff_ffff, 32'h0);
        exec(mk({1'b1, SAC_MIN10_WC}), 32'h1, 32'h2, 32'h0);
        exec(mk(SAC_MIN_PH) | 32'h0400_0000, 32'hffff_0001, 32'h0001_0002, 32'h0);
        wr(SAC_OFF_ENABLE, 32'h0);
        m_en = 1'b0;
        exec(mk(SAC_MIN_QB), 32'hffff_ffff, 32'h0101_0101, 32'h0);
        exec(mk(11'h7ff), 32'h1, 32'h1, 32'h0);
        wr(SAC_OFF_ENABLE, 32'h1);
        m_en = 1'b1;
        exec(mk(SAC_MIN_PH), 32'h0000_ffff, 32'h0000_0001, 32'h0);
        complete_run();
    end
endmodule
